// >>> design/stable_filter.sv
`timescale 1ns/100ps
module stable_filter import supervisor_pkg::*; #(
  parameter int STABLE_CYCLES = 16,
  parameter bit FILTER_FALL = 1'b1
) (
  // Clock, reset and enable.
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // Level in and qualified level out.
  input wire logic level_in,
  output logic level_out,
  output logic rise_pulse
);
  logic [31:0] cnt_reg;
  logic level_reg;
  logic pulse_reg;
  wire differ = level_in != level_reg;
  wire fast_fall = !FILTER_FALL && !level_in;
  wire done = cnt_reg == 32'(STABLE_CYCLES - 1);

  // The output moves only after the input has held its new level for the full count, except a fall, which passes at once when FILTER_FALL is low.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 32'h0000_0000;
      level_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else if (ce) begin
      pulse_reg <= differ && level_in && done;
      if (fast_fall || !differ) begin
        cnt_reg <= 32'h0000_0000;
        level_reg <= level_in;
      end else if (done) begin
        cnt_reg <= 32'h0000_0000;
        level_reg <= level_in;
      end else begin
        cnt_reg <= cnt_reg + 32'h0000_0001;
      end
    end
  end

  assign level_out = level_reg;
  assign rise_pulse = pulse_reg;
endmodule // stable_filter

// >>> design/supervisor_pkg.sv
package supervisor_pkg;
  // Clock and timing figures.
  localparam int CLK_FREQ_KHZ = 200_000;
  localparam int RESET_PULSE_MS = 100;
  localparam int MAINS_DELAY_MS = 20;
  localparam int CHARGE_TIME_MS = 4000;
  localparam int LOCKOUT_MS = 5000;
  localparam int RESET_PULSE_CYCLES = RESET_PULSE_MS * CLK_FREQ_KHZ;
  localparam int MAINS_DELAY_CYCLES = MAINS_DELAY_MS * CLK_FREQ_KHZ;
  localparam int CHARGE_CYCLES = CHARGE_TIME_MS * CLK_FREQ_KHZ;
  localparam int LOCKOUT_CYCLES = LOCKOUT_MS * CLK_FREQ_KHZ;
  // Error vector layout.
  localparam int ERR_N = 6;
  localparam int ERR_POWER_UV = 0;
  localparam int ERR_CHECK = 4;
  localparam int ERR_CTRL_MISSING = 5;
  // Register map, byte addresses.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] ERROR_OFFSET = 8'h08;
  localparam logic [7:0] TIMER_OFFSET = 8'h0C;
  // Field positions and reset values.
  localparam int CTRL_AUTO_BIT = 0;
  localparam int STATUS_MAINS_BIT = 16;
  localparam int STATUS_AVAIL_BIT = 17;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int SYNC_N = 10;
  // Sequencer states.
  typedef enum logic [12:0] {
    ST_POWER_OFF = 13'h0001,
    ST_BOOT_RECOVERY = 13'h0002,
    ST_FW_UPDATE = 13'h0004,
    ST_FW_START = 13'h0008,
    ST_SELF_TEST = 13'h0010,
    ST_CALIBRATE = 13'h0020,
    ST_MAINS_WAIT = 13'h0040,
    ST_OUTPUT_CHECK = 13'h0080,
    ST_OPERATIONAL = 13'h0100,
    ST_WARNING = 13'h0200,
    ST_FAULT = 13'h0400,
    ST_POWER_DOWN = 13'h0800,
    ST_NO_CTRL_SUPPLY = 13'h1000
  } sup_state_t;
endpackage

// >>> design/supply_unit_state_supervisor.sv
`timescale 1ns/100ps
module supply_unit_state_supervisor import supervisor_pkg::*; #(
  parameter int RESET_PULSE = RESET_PULSE_CYCLES,
  parameter int MAINS_DELAY = MAINS_DELAY_CYCLES,
  parameter logic [31:0] CHARGE = 32'(CHARGE_CYCLES),
  parameter logic [31:0] LOCK_CYCLES [ERR_N] = '{ERR_N{32'(LOCKOUT_CYCLES)}}
) (
  // Clock, reset and enable.
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pins from the analogue side and the controller.
  input wire logic fault_reset_pin,
  input wire logic ctrl_supply_ok,
  input wire logic ctrl_undervolt,
  input wire logic mains_detect,
  input wire logic mains_in_limits,
  input wire logic out_in_range,
  input wire logic ripple_ok,
  input wire logic warn_in,
  input wire logic [3:0] err_in,
  // Firmware side, same clock.
  input wire logic fw_corrupt,
  input wire logic debug_update_req,
  input wire logic update_done,
  input wire logic fw_ready,
  input wire logic self_test_done,
  input wire logic cal_done,
  // Status outputs and contact.
  output logic output_ready_out,
  output logic mains_present_out,
  output logic malfunction_out,
  output logic ready_to_operate_contact
);
  sup_state_t state_reg;
  sup_state_t state_next;
  logic [SYNC_N-1:0] pin_raw;
  logic [SYNC_N-1:0] sync1_reg;
  logic [SYNC_N-1:0] sync2_reg;
  logic [ERR_N-1:0] err_reg;
  logic [ERR_N-1:0] err_next;
  logic [ERR_N-1:0] err_set;
  logic [31:0] timer_reg;
  logic [31:0] timer_next;
  logic [31:0] ctrl_reg;
  logic [7:0] addr_reg;
  logic wr_reg;
  logic [31:0] rdata_reg;
  logic contact_reg;
  logic ready_reg;
  logic malf_reg;
  logic fault_reset_in;
  logic reset_req;
  logic mains_ok;

  // Every pin passes two flip-flops before any logic reads it.
  assign pin_raw = {err_in, warn_in, ripple_ok, out_in_range, mains_in_limits,
                    mains_detect, fault_reset_pin};
  wire ctrl_ok_s;
  wire ctrl_uv_s;
  logic [1:0] ctrl_sync1_reg;
  logic [1:0] ctrl_sync2_reg;
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else if (ce) begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  // Control supply flags get their own pair so power off is the reset view.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_sync1_reg <= 2'h0;
      ctrl_sync2_reg <= 2'h0;
    end else if (ce) begin
      ctrl_sync1_reg <= {ctrl_undervolt, ctrl_supply_ok};
      ctrl_sync2_reg <= ctrl_sync1_reg;
    end
  end
  assign ctrl_ok_s = ctrl_sync2_reg[0];
  assign ctrl_uv_s = ctrl_sync2_reg[1];

  // Named views of the synchronised pins.
  wire reset_pin_s = sync2_reg[0];
  wire mains_det_s = sync2_reg[1];
  wire mains_lim_s = sync2_reg[2];
  wire out_ok_s = sync2_reg[3];
  wire ripple_ok_s = sync2_reg[4];
  wire warn_s = sync2_reg[5];
  wire [3:0] err_s = sync2_reg[9:6];

  // Reset request qualifies only after a full width high; release is immediate.
  stable_filter #(
    .STABLE_CYCLES(RESET_PULSE),
    .FILTER_FALL(1'b0)
  ) u_reset_filter (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .level_in(reset_pin_s),
    .level_out(fault_reset_in),
    .rise_pulse(reset_req)
  );

  // Mains status follows the detector only once it has been stable.
  stable_filter #(
    .STABLE_CYCLES(MAINS_DELAY),
    .FILTER_FALL(1'b1)
  ) u_mains_filter (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .level_in(mains_det_s),
    .level_out(mains_ok),
    .rise_pulse()
  );

  // Longest lockout among the errors that are latched.
  function automatic logic [31:0] lock_max(input logic [ERR_N-1:0] errs);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < ERR_N; i++) begin
      if (errs[i] && LOCK_CYCLES[i] > m) begin
        m = LOCK_CYCLES[i];
      end
    end
    return m;
  endfunction

  // State groups used by the decode below.
  wire st_run = state_reg inside {ST_OPERATIONAL, ST_WARNING};
  wire st_monitor = st_run || state_reg == ST_OUTPUT_CHECK;
  wire drawing = st_run && mains_ok;
  wire auto_en = ctrl_reg[CTRL_AUTO_BIT];
  wire timer_zero = timer_reg == 32'h0000_0000;
  wire cause_gone = err_s == 4'h0;
  wire check_end = state_reg == ST_OUTPUT_CHECK && timer_zero;
  wire check_bad = state_reg == ST_OUTPUT_CHECK && (!ripple_ok_s || (check_end && !out_ok_s));

  // Only the reset pin, automatic recovery or a supply cycle can lift a fault; bus writes cannot.
  wire recover_src = reset_req || auto_en;
  wire recover = state_reg == ST_FAULT && timer_zero && cause_gone && recover_src;

  // New errors; undervoltage stays remanent only while energy is drawn.
  always_comb begin
    err_set = '0;
    if (st_monitor) begin
      err_set[3:1] = err_s[3:1];
      err_set[ERR_POWER_UV] = err_s[ERR_POWER_UV] && drawing;
    end
    err_set[ERR_CHECK] = check_bad;
    err_set[ERR_CTRL_MISSING] = state_reg == ST_NO_CTRL_SUPPLY;
  end

  // A new error beats the clear of a recovery in the same cycle; a supply cycle clears too.
  wire err_clear = recover || state_reg == ST_POWER_OFF;
  assign err_next = (err_clear ? '0 : err_reg) | err_set;

  // Next state; supply loss and undervoltage take precedence over everything.
  always_comb begin
    state_next = state_reg;
    if (!ctrl_ok_s) begin
      state_next = ST_POWER_OFF;
    end else if (ctrl_uv_s) begin
      state_next = ST_POWER_DOWN;
    end else begin
      unique case (state_reg)
        ST_POWER_OFF: begin
          state_next = fw_corrupt ? ST_BOOT_RECOVERY : ST_FW_START;
        end
        ST_BOOT_RECOVERY: begin
          if (debug_update_req) begin
            state_next = ST_FW_UPDATE;
          end
        end
        ST_FW_UPDATE: begin
          if (update_done) begin
            state_next = ST_FW_START;
          end
        end
        ST_FW_START: begin
          if (fw_ready) begin
            state_next = ST_SELF_TEST;
          end
        end
        ST_SELF_TEST: begin
          if (self_test_done) begin
            state_next = ST_CALIBRATE;
          end
        end
        ST_CALIBRATE: begin
          if (cal_done) begin
            state_next = ST_MAINS_WAIT;
          end
        end
        ST_MAINS_WAIT: begin
          if (mains_lim_s) begin
            state_next = ST_OUTPUT_CHECK;
          end
        end
        ST_OUTPUT_CHECK: begin
          if (check_bad) begin
            state_next = ST_FAULT;
          end else if (check_end) begin
            state_next = ST_OPERATIONAL;
          end
        end
        ST_OPERATIONAL, ST_WARNING: begin
          if (err_set != '0) begin
            state_next = ST_FAULT;
          end else begin
            state_next = warn_s ? ST_WARNING : ST_OPERATIONAL;
          end
        end
        ST_FAULT: begin
          if (recover) begin
            state_next = ST_MAINS_WAIT;
          end
        end
        ST_POWER_DOWN: begin
          state_next = ST_NO_CTRL_SUPPLY;
        end
        ST_NO_CTRL_SUPPLY: begin
          state_next = ST_FAULT;
        end
        default: begin
          state_next = ST_POWER_OFF;
        end
      endcase
    end
  end

  // One timer serves the charge window and the lockout wait.
  always_comb begin
    timer_next = timer_zero ? timer_reg : timer_reg - 32'h0000_0001;
    if (state_next == ST_OUTPUT_CHECK && state_reg != ST_OUTPUT_CHECK) begin
      timer_next = CHARGE - 32'h0000_0001;
    end else if (state_next == ST_FAULT && state_reg != ST_FAULT) begin
      timer_next = lock_max(err_next);
    end
  end

  // Contact closes only in states that want mains energy.
  wire contact_next = state_next inside {ST_MAINS_WAIT, ST_OUTPUT_CHECK,
                                         ST_OPERATIONAL, ST_WARNING};
  wire malf_next = state_next inside {ST_FAULT, ST_NO_CTRL_SUPPLY};
  // Ready follows the contact a cycle late, so it drops only once the contact is open.
  wire ready_next = contact_reg && st_run && !malf_reg;

  // Sequencer and status registers.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_POWER_OFF;
      err_reg <= '0;
      timer_reg <= 32'h0000_0000;
      contact_reg <= 1'b0;
      ready_reg <= 1'b0;
      malf_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      err_reg <= err_next;
      timer_reg <= timer_next;
      contact_reg <= contact_next;
      ready_reg <= ready_next;
      malf_reg <= malf_next;
    end
  end

  // Bus address phase decode.
  wire addr_phase = hsel && hready && htrans[1];
  wire take_wr = addr_phase && hwrite && hsize == HSIZE_WORD;
  wire mains_avail = mains_ok && st_run;
  wire [31:0] status_word = {14'h0000, mains_avail, mains_ok, 3'h0, state_reg};
  wire [31:0] read_mux = haddr == CTRL_OFFSET ? ctrl_reg :
                         haddr == STATUS_OFFSET ? status_word :
                         haddr == ERROR_OFFSET ? {26'h0000000, err_reg} :
                         haddr == TIMER_OFFSET ? timer_reg : 32'h0000_0000;

  // Zero wait states: read data is fetched at the address phase edge.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_reg <= 8'h00;
      wr_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      ctrl_reg <= CTRL_RESET;
    end else if (ce) begin
      wr_reg <= take_wr;
      if (addr_phase) begin
        addr_reg <= haddr;
        rdata_reg <= read_mux;
      end
      if (wr_reg && addr_reg == CTRL_OFFSET) begin
        ctrl_reg <= {31'h0000_0000, hwdata[CTRL_AUTO_BIT]};
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
  assign output_ready_out = ready_reg;
  assign mains_present_out = mains_ok;
  assign malfunction_out = malf_reg;
  assign ready_to_operate_contact = contact_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_fault_contact;
    state_reg == ST_FAULT |-> !ready_to_operate_contact;
  endproperty
  a_fault_contact: assert property (p_fault_contact)
    else $error("Contact closed in fault state.");

  property p_power_off;
    ce && !ctrl_ok_s |=> state_reg == ST_POWER_OFF && !ready_to_operate_contact;
  endproperty
  a_power_off: assert property (p_power_off)
    else $error("Supply absent but not in power off.");

  property p_malf;
    malfunction_out == (state_reg inside {ST_FAULT, ST_NO_CTRL_SUPPLY});
  endproperty
  a_malf: assert property (p_malf)
    else $error("Malfunction line disagrees with state.");

  property p_ready;
    output_ready_out |-> $past(ready_to_operate_contact) && !$past(malfunction_out);
  endproperty
  a_ready: assert property (p_ready)
    else $error("Ready shown without closed contact.");

  property p_wait;
    ce && state_reg == ST_MAINS_WAIT && !mains_lim_s && ctrl_ok_s && !ctrl_uv_s
      |=> state_reg == ST_MAINS_WAIT && ready_to_operate_contact;
  endproperty
  a_wait: assert property (p_wait)
    else $error("Left mains wait without valid input.");

  property p_lockout;
    ce && state_reg == ST_FAULT && !timer_zero |=> state_reg != ST_MAINS_WAIT;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("Fault reset taken during lockout.");

  property p_down;
    ce && ctrl_ok_s && ctrl_uv_s |=> state_reg == ST_POWER_DOWN ##1 !ready_to_operate_contact;
  endproperty
  a_down: assert property (p_down)
    else $error("Undervoltage did not enter power down.");

  property p_order;
    state_reg == ST_CALIBRATE && $past(state_reg) != ST_CALIBRATE
      |-> $past(state_reg) == ST_SELF_TEST;
  endproperty
  a_order: assert property (p_order)
    else $error("Calibration entered out of order.");
endmodule // supply_unit_state_supervisor

// >>> dv/reset_controller_model.sv
`timescale 1ns/100ps
// Machine controller side of the block: it owns only the fault reset pin.
module reset_controller_model (
  // Clock and driven pin.
  input wire logic ref_clk,
  output logic fault_reset_pin
);
  // The controller output idles low, so no reset is requested outside a pulse.
  initial fault_reset_pin = 1'b0;

  // Holds the pin high for a whole number of cycles, then releases it low.
  task automatic pulse(input int width);
    @(posedge ref_clk) fault_reset_pin <= 1'b1;
    repeat (width) @(posedge ref_clk);
    fault_reset_pin <= 1'b0;
  endtask
endmodule // reset_controller_model

// >>> dv/tb.sv
`timescale 1ns/100ps
module tb import supervisor_pkg::*; ;
  typedef struct {
    logic [8:0] pins;
    int wait_c;
    sup_state_t st;
    logic ctc;
    logic rdy;
    logic malf;
  } row_t;
  logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
  logic ctrl_supply_ok = 1'b0, ctrl_undervolt = 1'b0, mains_detect = 1'b0;
  logic mains_in_limits = 1'b0, out_in_range = 1'b0, ripple_ok = 1'b0, warn_in = 1'b0;
  logic fw_ready = 1'b0, self_test_done = 1'b0, cal_done = 1'b0;
  logic ce = 1'b1, fw_corrupt = 1'b0, debug_update_req = 1'b0, update_done = 1'b0;
  logic [3:0] err_in = 4'h0;
  logic fault_reset_pin, output_ready_out, mains_present_out, malfunction_out;
  logic ready_to_operate_contact;
  int errors = 0, checks_done = 0;
  // Pin order: supply, fw, self test, cal, limits, range, ripple, warn, err1.
  row_t rows [8] = '{
    '{9'h100, 12, ST_FW_START, 1'b0, 1'b0, 1'b0},
    '{9'h180, 12, ST_SELF_TEST, 1'b0, 1'b0, 1'b0},
    '{9'h1C0, 12, ST_CALIBRATE, 1'b0, 1'b0, 1'b0},
    '{9'h1E0, 12, ST_MAINS_WAIT, 1'b1, 1'b0, 1'b0},
    '{9'h1FC, 40, ST_OPERATIONAL, 1'b1, 1'b1, 1'b0},
    '{9'h1FE, 12, ST_WARNING, 1'b1, 1'b1, 1'b0},
    '{9'h1FC, 12, ST_OPERATIONAL, 1'b1, 1'b1, 1'b0},
    '{9'h1FD, 12, ST_FAULT, 1'b0, 1'b0, 1'b1}
  };

  // Short counts keep the run brief; expectations below follow these values.
  supply_unit_state_supervisor #(.RESET_PULSE(8), .MAINS_DELAY(8), .CHARGE(32'd16),
    .LOCK_CYCLES('{ERR_N{32'd10}})) u_supply_unit_state_supervisor (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fault_reset_pin(fault_reset_pin),
    .ctrl_supply_ok(ctrl_supply_ok), .ctrl_undervolt(ctrl_undervolt),
    .mains_detect(mains_detect), .mains_in_limits(mains_in_limits),
    .out_in_range(out_in_range), .ripple_ok(ripple_ok), .warn_in(warn_in), .err_in(err_in),
    .fw_corrupt(fw_corrupt), .debug_update_req(debug_update_req), .update_done(update_done),
    .fw_ready(fw_ready), .self_test_done(self_test_done), .cal_done(cal_done),
    .output_ready_out(output_ready_out), .mains_present_out(mains_present_out),
    .malfunction_out(malfunction_out), .ready_to_operate_contact(ready_to_operate_contact));

  reset_controller_model u_reset_controller_model (.ref_clk(ref_clk),
    .fault_reset_pin(fault_reset_pin));

  // Free-running 200 MHz clock.
  always #2.5 ref_clk = ~ref_clk;

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Compares with case equality so that unknowns never match.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Waits for hready at a rising edge; a slave that never answers ends the run.
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        errors++;
        end_of_test();
      end
      @(posedge ref_clk);
    end
  endtask

  // One single word transfer: address phase, then data phase.
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    d = hrdata;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    logic [31:0] d;
    ahb(a, 1'b0, 32'h0000_0000, d);
    check(name, d & m, e);
  endtask

  // Watchdog: a hang counts as a mismatch and goes to the closing report.
  initial begin
    #250000;
    errors++;
    end_of_test();
  end

  // Main sequence: table of bring-up steps, then recovery and supply cases.
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk("state", STATUS_OFFSET, 32'h1FFF, 32'(ST_POWER_OFF));
    rd_chk("ctrl", CTRL_OFFSET, 32'hFFFF_FFFF, CTRL_RESET);
    check("contact", ready_to_operate_contact, 32'h0);
    foreach (rows[i]) begin
      {ctrl_supply_ok, fw_ready, self_test_done, cal_done, mains_in_limits, out_in_range,
       ripple_ok, warn_in, err_in[1]} <= rows[i].pins;
      cyc(rows[i].wait_c);
      rd_chk("state", STATUS_OFFSET, 32'h1FFF, 32'(rows[i].st));
      check("contact", ready_to_operate_contact, 32'(rows[i].ctc));
      check("ready", output_ready_out, 32'(rows[i].rdy));
      check("malfunction", malfunction_out, 32'(rows[i].malf));
    end
    // A qualified pulse while the cause is still present must not recover.
    u_reset_controller_model.pulse(20);
    cyc(6);
    rd_chk("state", STATUS_OFFSET, 32'h1FFF, 32'(ST_FAULT));
    err_in <= 4'h0;
    mains_in_limits <= 1'b0;
    cyc(6);
    rd_chk("errors", ERROR_OFFSET, 32'h2, 32'h2);
    // A pulse shorter than the qualified width is ignored.
    u_reset_controller_model.pulse(4);
    cyc(6);
    rd_chk("state", STATUS_OFFSET, 32'h1FFF, 32'(ST_FAULT));
    u_reset_controller_model.pulse(20);
    cyc(6);
    rd_chk("state", STATUS_OFFSET, 32'h1FFF, 32'(ST_MAINS_WAIT));
    rd_chk("errors", ERROR_OFFSET, 32'h3F, 32'h0);
    check("contact", ready_to_operate_contact, 32'h1);
    check("malfunction", malfunction_out, 32'h0);
    // Bad ripple during the output check ends in the error state.
    ripple_ok <= 1'b0;
    mains_in_limits <= 1'b1;
    cyc(10);
    rd_chk("state", STATUS_OFFSET, 32'h1FFF, 32'(ST_FAULT));
    rd_chk("errors", ERROR_OFFSET, 32'h10, 32'h10);
    check("contact", ready_to_operate_contact, 32'h0);
    check("ready", output_ready_out, 32'h0);
    // Lockout is over and causes are gone, yet bus traffic alone must not lift the fault.
    ripple_ok <= 1'b1;
    mains_in_limits <= 1'b0;
    hsize <= 3'h0;
    ahb(CTRL_OFFSET, 1'b1, 32'h0000_0001, rd);
    hsize <= HSIZE_WORD;
    ahb(ERROR_OFFSET, 1'b1, 32'hFFFF_FFFF, rd);
    cyc(4);
    rd_chk("state", STATUS_OFFSET, 32'h1FFF, 32'(ST_FAULT));
    rd_chk("ctrl", CTRL_OFFSET, 32'hFFFF_FFFF, 32'h0000_0000);
    // Enabling automatic recovery is a recovery source of its own.
    ahb(CTRL_OFFSET, 1'b1, 32'h0000_0001, rd);
    cyc(4);
    rd_chk("ctrl", CTRL_OFFSET, 32'hFFFF_FFFF, 32'h0000_0001);
    rd_chk("state", STATUS_OFFSET, 32'h1FFF, 32'(ST_MAINS_WAIT));
    rd_chk("errors", ERROR_OFFSET, 32'h3F, 32'h0);
    ahb(CTRL_OFFSET, 1'b1, 32'h0000_0000, rd);
    rd_chk("unmapped", 8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    // A short mains glitch is filtered; a stable level shows up.
    mains_detect <= 1'b1;
    cyc(4);
    mains_detect <= 1'b0;
    cyc(20);
    check("mains", mains_present_out, 32'h0);
    mains_detect <= 1'b1;
    cyc(20);
    check("mains", mains_present_out, 32'h1);
    // Control undervoltage, then its return, then loss of the supply.
    ctrl_undervolt <= 1'b1;
    cyc(6);
    rd_chk("state", STATUS_OFFSET, 32'h1FFF, 32'(ST_POWER_DOWN));
    check("contact", ready_to_operate_contact, 32'h0);
    ctrl_undervolt <= 1'b0;
    cyc(8);
    rd_chk("state", STATUS_OFFSET, 32'h1FFF, 32'(ST_FAULT));
    rd_chk("errors", ERROR_OFFSET, 32'h20, 32'h20);
    check("malfunction", malfunction_out, 32'h1);
    ctrl_supply_ok <= 1'b0;
    cyc(6);
    rd_chk("state", STATUS_OFFSET, 32'h1FFF, 32'(ST_POWER_OFF));
    check("contact", ready_to_operate_contact, 32'h0);
    rd_chk("errors", ERROR_OFFSET, 32'h3F, 32'h0);
    // Bad firmware goes through recovery and update before a normal start.
    fw_corrupt <= 1'b1;
    {fw_ready, self_test_done, cal_done} <= 3'h0;
    ctrl_supply_ok <= 1'b1;
    cyc(6);
    rd_chk("state", STATUS_OFFSET, 32'h1FFF, 32'(ST_BOOT_RECOVERY));
    debug_update_req <= 1'b1;
    cyc(2);
    rd_chk("state", STATUS_OFFSET, 32'h1FFF, 32'(ST_FW_UPDATE));
    update_done <= 1'b1;
    cyc(2);
    rd_chk("state", STATUS_OFFSET, 32'h1FFF, 32'(ST_FW_START));
    // With the enable low nothing moves, even though every start step is ready.
    ce <= 1'b0;
    {fw_ready, self_test_done, cal_done} <= 3'h7;
    cyc(8);
    check("contact", ready_to_operate_contact, 32'h0);
    ce <= 1'b1;
    cyc(6);
    rd_chk("state", STATUS_OFFSET, 32'h1FFF, 32'(ST_MAINS_WAIT));
    check("contact", ready_to_operate_contact, 32'h1);
    // A reset in mid-run opens the contact at once and clears the control word.
    ahb(CTRL_OFFSET, 1'b1, 32'h0000_0001, rd);
    cyc(1);
    rst <= 1'b1;
    cyc(2);
    check("contact", ready_to_operate_contact, 32'h0);
    check("mains", mains_present_out, 32'h0);
    check("malfunction", malfunction_out, 32'h0);
    rst <= 1'b0;
    rd_chk("state", STATUS_OFFSET, 32'h1FFF, 32'(ST_POWER_OFF));
    rd_chk("ctrl", CTRL_OFFSET, 32'hFFFF_FFFF, CTRL_RESET);
    end_of_test();
  end
endmodule // tb
